// File: include/sysmod_pkg.sv
package sysmod_pkg;

  // register port
  localparam logic [7:0] MCR_OFFSET = 8'h00;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // show cycle behaviour
  typedef enum logic [1:0] {
    SHOW_OFF      = 2'b00,
    SHOW_NO_ARB   = 2'b01,
    SHOW_ARB      = 2'b10,
    SHOW_ARB_HALT = 2'b11
  } show_mode_t;

  // configuration register layout, bit 15 first
  typedef struct packed {
    logic       clock_output_disable;
    logic       halt_watchdog_timer_gate;
    logic       halt_bus_monitor_gate;
    logic       pipeline_pin_disable;
    logic       reserved;
    logic       pin_speed_select;
    show_mode_t show_cycle_mode;
    logic       supervisor_space_select;
    logic       register_block_placement;
    logic       low_address_pin_disable;
    logic       strobe_pin_disable;
    logic [3:0] interrupt_arbitration_priority;
  } mcr_t;

  // reset values
  localparam logic RST_CLOCK_OUTPUT_DISABLE = 1'b0;
  localparam logic RST_HALT_WDT_GATE = 1'b0;
  localparam logic RST_HALT_BMON_GATE = 1'b0;
  localparam logic RST_PIN_SPEED = 1'b0;
  localparam show_mode_t RST_SHOW_MODE = SHOW_OFF;
  localparam logic RST_SUPERVISOR = 1'b1;
  localparam logic RST_PLACEMENT = 1'b1;
  localparam logic [3:0] RST_INTERRUPT_ARBITRATION_PRIORITY = 4'hf;
  // noise control bits until the strap is taken: single-chip
  localparam logic RST_PIN_DISABLE = 1'b1;

  // register block decode, address bits 23:12
  localparam logic [11:0] BLOCK_LOW = 12'h7ff;
  localparam logic [11:0] BLOCK_HIGH = 12'hfff;

  // strap capture sequence after reset release
  typedef enum logic [1:0] {
    ST_SYNC = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } strap_state_t;
  localparam logic [1:0] STRAP_SYNC_CYCLES = 2'h2;

  localparam int PIN_SPEED_WIDTH = 8;

endpackage

// File: rtl/write_once_bit.sv
module write_once_bit (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // strap load
  input wire logic load_i,
  input wire logic load_value_i,
  // software write
  input wire logic write_i,
  input wire logic write_value_i,
  // state
  output logic value_o
);

  logic value;
  logic locked;
  logic next_value;
  logic next_locked;

  always_comb begin
    next_value = value;
    next_locked = locked;
    if (load_i) begin
      next_value = load_value_i;
    end else if (write_i && !locked) begin
      // first write after reset only
      next_value = write_value_i;
      next_locked = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      value <= 1'b1;
      // lock cleared by every reset
      locked <= 1'b0;
    end else begin
      value <= next_value;
      locked <= next_locked;
    end
  end

  assign value_o = value;

endmodule

// File: rtl/sysmod_config.sv
// Chosen here: strobed register access and the register offsets.
module sysmod_config (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // mode strap pin
  input wire logic BUS_ERROR_INPUT_I,
  // debug and protection
  input wire logic BACKGROUND_DEBUG_STATE_I,
  input wire logic BREAKPOINT_I,
  output logic HALT_O,
  output logic WDT_RUN_O,
  output logic BMON_RUN_O,
  // clock output pin
  output logic SYSTEM_CLOCK_OUTPUT_PIN_OE_O,
  // pipeline tracking pins
  input wire logic PIPE_ADVANCE_I,
  input wire logic OPERAND_FETCH_I,
  output logic PIPELINE_ADVANCE_PIN_O,
  output logic PIPELINE_ADVANCE_PIN_OE_O,
  output logic OPERAND_FETCH_PIN_O,
  output logic OPERAND_FETCH_PIN_OE_O,
  // low address pins
  input wire logic [2:0] ADDR_LOW_I,
  input wire logic ADDR_LOW_DRIVE_I,
  output logic [2:0] ADDR_LOW_O,
  output logic ADDR_LOW_OE_O,
  // read/write strobe pin
  input wire logic STROBE_I,
  input wire logic STROBE_DRIVE_I,
  output logic STROBE_O,
  output logic STROBE_OE_O,
  // pin speed
  input wire logic [sysmod_pkg::PIN_SPEED_WIDTH-1:0] SLOW_REQ_I,
  output logic [sysmod_pkg::PIN_SPEED_WIDTH-1:0] PIN_SLOW_O,
  // show cycles
  input wire logic INTERNAL_XFER_I,
  output logic SHOW_CYCLE_O,
  output logic EXT_ARB_ENABLE_O,
  output logic GRANT_HALTS_O,
  output logic EXT_SELECT_BLOCK_O,
  // register block access
  input wire logic [23:0] ACCESS_ADDR_I,
  input wire logic ACCESS_SUPERVISOR_I,
  output logic REGBLOCK_HIT_O,
  output logic GLOBAL_ACCESS_OK_O,
  // interrupt arbitration and mode
  output logic [3:0] INTERRUPT_ARBITRATION_PRIORITY_O,
  output logic SINGLE_CHIP_O
);

  // strap synchroniser and sequence
  logic bus_error_input_meta;
  logic bus_error_input_sync;
  sysmod_pkg::strap_state_t state;
  sysmod_pkg::strap_state_t next_state;
  logic [1:0] count;
  logic [1:0] next_count;
  logic single_chip;
  logic next_single_chip;
  logic strap_load;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bus_error_input_meta <= 1'b1;
      bus_error_input_sync <= 1'b1;
    end else begin
      bus_error_input_meta <= BUS_ERROR_INPUT_I;
      bus_error_input_sync <= bus_error_input_meta;
    end
  end

  always_comb begin
    next_state = state;
    next_count = count;
    next_single_chip = single_chip;
    strap_load = 1'b0;
    case (state)
      sysmod_pkg::ST_SYNC: begin
        next_count = count + 2'h1;
        if (count == sysmod_pkg::STRAP_SYNC_CYCLES) begin
          next_state = sysmod_pkg::ST_LOAD;
        end
      end
      sysmod_pkg::ST_LOAD: begin
        strap_load = 1'b1;
        next_single_chip = !bus_error_input_sync;
        next_state = sysmod_pkg::ST_RUN;
      end
      sysmod_pkg::ST_RUN: next_state = sysmod_pkg::ST_RUN;
      default: next_state = sysmod_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= sysmod_pkg::ST_SYNC;
      count <= 2'h0;
      single_chip <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      single_chip <= next_single_chip;
    end
  end

  // register write and read
  sysmod_pkg::mcr_t mcr;
  sysmod_pkg::mcr_t next_mcr;
  sysmod_pkg::mcr_t wr_view;
  sysmod_pkg::mcr_t rd_view;
  logic [15:0] next_rdata;
  logic hit;
  logic write_mcr;
  logic placement;
  logic low_addr_dis;
  logic strobe_dis;

  assign hit = ADDR_I == sysmod_pkg::MCR_OFFSET;
  assign write_mcr = WR_I && hit;
  assign wr_view = sysmod_pkg::mcr_t'(WDATA_I);

  always_comb begin
    next_mcr = mcr;
    if (strap_load) begin
      next_mcr.pipeline_pin_disable = !bus_error_input_sync;
    end else if (write_mcr) begin
      next_mcr = wr_view;
    end
    next_mcr.reserved = 1'b0;
    next_mcr.register_block_placement = 1'b0;
    next_mcr.low_address_pin_disable = 1'b0;
    next_mcr.strobe_pin_disable = 1'b0;
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mcr <= '{
        clock_output_disable: sysmod_pkg::RST_CLOCK_OUTPUT_DISABLE,
        halt_watchdog_timer_gate: sysmod_pkg::RST_HALT_WDT_GATE,
        halt_bus_monitor_gate: sysmod_pkg::RST_HALT_BMON_GATE,
        pipeline_pin_disable: sysmod_pkg::RST_PIN_DISABLE,
        reserved: 1'b0,
        pin_speed_select: sysmod_pkg::RST_PIN_SPEED,
        show_cycle_mode: sysmod_pkg::RST_SHOW_MODE,
        supervisor_space_select: sysmod_pkg::RST_SUPERVISOR,
        register_block_placement: 1'b0,
        low_address_pin_disable: 1'b0,
        strobe_pin_disable: 1'b0,
        interrupt_arbitration_priority: sysmod_pkg::RST_INTERRUPT_ARBITRATION_PRIORITY
      };
    end else begin
      mcr <= next_mcr;
    end
  end

  // write-once bits; load value for placement keeps its own state
  write_once_bit u_placement (
    .clock_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .load_i(1'b0),
    .load_value_i(sysmod_pkg::RST_PLACEMENT),
    .write_i(write_mcr),
    .write_value_i(wr_view.register_block_placement),
    .value_o(placement)
  );
  write_once_bit u_low_addr (
    .clock_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .load_i(strap_load),
    .load_value_i(!bus_error_input_sync),
    .write_i(write_mcr),
    .write_value_i(wr_view.low_address_pin_disable),
    .value_o(low_addr_dis)
  );
  write_once_bit u_strobe (
    .clock_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .load_i(strap_load),
    .load_value_i(!bus_error_input_sync),
    .write_i(write_mcr),
    .write_value_i(wr_view.strobe_pin_disable),
    .value_o(strobe_dis)
  );

  always_comb begin
    rd_view = mcr;
    rd_view.reserved = 1'b0;
    rd_view.register_block_placement = placement;
    rd_view.low_address_pin_disable = low_addr_dis;
    rd_view.strobe_pin_disable = strobe_dis;
    next_rdata = sysmod_pkg::READ_IDLE;
    if (RD_I && hit) begin
      next_rdata = rd_view;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RDATA_O <= sysmod_pkg::READ_IDLE;
    end else begin
      RDATA_O <= next_rdata;
    end
  end

  // block outputs
  logic next_halt;
  logic next_clk_oe;
  logic next_pa;
  logic next_pa_oe;
  logic next_of;
  logic next_of_oe;
  logic [2:0] next_al;
  logic next_al_oe;
  logic next_st;
  logic next_st_oe;
  logic [sysmod_pkg::PIN_SPEED_WIDTH-1:0] next_slow;
  logic next_show;
  logic next_arb;
  logic next_grant_halt;
  logic next_sel_block;
  logic next_regblock_hit;
  logic next_global_ok;
  logic track_on;

  always_comb begin
    next_halt = BACKGROUND_DEBUG_STATE_I;
    next_clk_oe = !mcr.clock_output_disable;
    track_on = !mcr.pipeline_pin_disable || BREAKPOINT_I
      || BACKGROUND_DEBUG_STATE_I;
    next_pa = PIPE_ADVANCE_I;
    next_of = OPERAND_FETCH_I;
    next_pa_oe = track_on;
    next_of_oe = track_on;
    next_al = ADDR_LOW_I;
    next_al_oe = ADDR_LOW_DRIVE_I && !low_addr_dis;
    next_st = STROBE_I;
    next_st_oe = STROBE_DRIVE_I && !strobe_dis;
    next_slow = SLOW_REQ_I
      & {sysmod_pkg::PIN_SPEED_WIDTH{mcr.pin_speed_select}};
    next_show = 1'b0;
    next_arb = 1'b1;
    next_grant_halt = 1'b0;
    case (mcr.show_cycle_mode)
      sysmod_pkg::SHOW_OFF: next_show = 1'b0;
      sysmod_pkg::SHOW_NO_ARB: begin
        next_show = 1'b1;
        next_arb = 1'b0;
      end
      sysmod_pkg::SHOW_ARB: next_show = 1'b1;
      sysmod_pkg::SHOW_ARB_HALT: begin
        next_show = 1'b1;
        next_grant_halt = 1'b1;
      end
      default: next_show = 1'b0;
    endcase
    next_sel_block = next_show && INTERNAL_XFER_I;
    next_regblock_hit = ACCESS_ADDR_I[23:12] ==
      (placement ? sysmod_pkg::BLOCK_HIGH : sysmod_pkg::BLOCK_LOW);
    next_global_ok = next_regblock_hit
      && (ACCESS_SUPERVISOR_I || !mcr.supervisor_space_select);
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      HALT_O <= 1'b0;
      WDT_RUN_O <= 1'b1;
      BMON_RUN_O <= 1'b1;
      SYSTEM_CLOCK_OUTPUT_PIN_OE_O <= 1'b0;
      PIPELINE_ADVANCE_PIN_O <= 1'b0;
      PIPELINE_ADVANCE_PIN_OE_O <= 1'b0;
      OPERAND_FETCH_PIN_O <= 1'b0;
      OPERAND_FETCH_PIN_OE_O <= 1'b0;
      ADDR_LOW_O <= 3'h0;
      ADDR_LOW_OE_O <= 1'b0;
      STROBE_O <= 1'b0;
      STROBE_OE_O <= 1'b0;
      PIN_SLOW_O <= '0;
      SHOW_CYCLE_O <= 1'b0;
      EXT_ARB_ENABLE_O <= 1'b1;
      GRANT_HALTS_O <= 1'b0;
      EXT_SELECT_BLOCK_O <= 1'b0;
      REGBLOCK_HIT_O <= 1'b0;
      GLOBAL_ACCESS_OK_O <= 1'b0;
      INTERRUPT_ARBITRATION_PRIORITY_O <= sysmod_pkg::RST_INTERRUPT_ARBITRATION_PRIORITY;
      SINGLE_CHIP_O <= 1'b1;
    end else begin
      HALT_O <= next_halt;
      WDT_RUN_O <= !(next_halt && mcr.halt_watchdog_timer_gate);
      BMON_RUN_O <= !(next_halt && mcr.halt_bus_monitor_gate);
      SYSTEM_CLOCK_OUTPUT_PIN_OE_O <= next_clk_oe;
      PIPELINE_ADVANCE_PIN_O <= next_pa;
      PIPELINE_ADVANCE_PIN_OE_O <= next_pa_oe;
      OPERAND_FETCH_PIN_O <= next_of;
      OPERAND_FETCH_PIN_OE_O <= next_of_oe;
      ADDR_LOW_O <= next_al;
      ADDR_LOW_OE_O <= next_al_oe;
      STROBE_O <= next_st;
      STROBE_OE_O <= next_st_oe;
      PIN_SLOW_O <= next_slow;
      SHOW_CYCLE_O <= next_show;
      EXT_ARB_ENABLE_O <= next_arb;
      GRANT_HALTS_O <= next_grant_halt;
      EXT_SELECT_BLOCK_O <= next_sel_block;
      REGBLOCK_HIT_O <= next_regblock_hit;
      GLOBAL_ACCESS_OK_O <= next_global_ok;
      INTERRUPT_ARBITRATION_PRIORITY_O <= mcr.interrupt_arbitration_priority;
      SINGLE_CHIP_O <= single_chip;
    end
  end

endmodule

// File: tb/sysmod_config_props.sv
module sysmod_config_props (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  // debug
  input wire logic BACKGROUND_DEBUG_STATE_I,
  input wire logic HALT_O,
  input wire logic WDT_RUN_O,
  // pins
  input wire logic SYSTEM_CLOCK_OUTPUT_PIN_OE_O,
  input wire logic STROBE_DRIVE_I,
  input wire logic STROBE_OE_O,
  // show cycles
  input wire logic INTERNAL_XFER_I,
  input wire logic SHOW_CYCLE_O,
  input wire logic EXT_ARB_ENABLE_O,
  input wire logic GRANT_HALTS_O,
  input wire logic EXT_SELECT_BLOCK_O,
  // decode and arbitration
  input wire logic [23:0] ACCESS_ADDR_I,
  input wire logic REGBLOCK_HIT_O,
  input wire logic [3:0] INTERRUPT_ARBITRATION_PRIORITY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  wire wr0 = WR_I && ADDR_I == 8'h00;

  property p_clk_oe;
    wr0 |=> ##1 SYSTEM_CLOCK_OUTPUT_PIN_OE_O == !$past(WDATA_I[15], 2);
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin enable");
  property p_interrupt_arbitration_priority;
    wr0 |=> ##1 INTERRUPT_ARBITRATION_PRIORITY_O == $past(WDATA_I[3:0], 2);
  endproperty
  a_interrupt_arbitration_priority: assert property (p_interrupt_arbitration_priority) else $error("arbitration copy");
  property p_halt;
    $rose(BACKGROUND_DEBUG_STATE_I) |=> HALT_O;
  endproperty
  a_halt: assert property (p_halt) else $error("halt late");
  property p_wdt;
    !WDT_RUN_O |-> $past(BACKGROUND_DEBUG_STATE_I);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog stopped");
  property p_strobe;
    STROBE_OE_O |-> $past(STROBE_DRIVE_I);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe driven");
  property p_show;
    GRANT_HALTS_O |-> SHOW_CYCLE_O && EXT_ARB_ENABLE_O;
  endproperty
  a_show: assert property (p_show) else $error("show decode");
  property p_sel;
    EXT_SELECT_BLOCK_O == (SHOW_CYCLE_O && $past(INTERNAL_XFER_I));
  endproperty
  a_sel: assert property (p_sel) else $error("select block");
  property p_hit;
    REGBLOCK_HIT_O |-> $past(ACCESS_ADDR_I[23:12]) inside {12'h7ff, 12'hfff};
  endproperty
  a_hit: assert property (p_hit) else $error("block decode");
  property p_rd;
    RD_I && ADDR_I != 8'h00 |=> RDATA_O == 16'h0000;
  endproperty
  a_rd: assert property (p_rd) else $error("unmapped read");
endmodule

bind sysmod_config sysmod_config_props props (.*);

// File: tb/test_sysmod_config.sv
`define CHK(n, e, g) begin samples_checked++; \
  if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module test_sysmod_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_I = 0, ARST_N_I, WR_I, RD_I, BUS_ERROR_INPUT_I;
  logic BACKGROUND_DEBUG_STATE_I, BREAKPOINT_I, PIPE_ADVANCE_I;
  logic OPERAND_FETCH_I, ADDR_LOW_DRIVE_I, STROBE_I, STROBE_DRIVE_I;
  logic INTERNAL_XFER_I, ACCESS_SUPERVISOR_I;
  logic [sysmod_pkg::PIN_SPEED_WIDTH-1:0] SLOW_REQ_I, PIN_SLOW_O;
  logic [7:0] ADDR_I;
  logic [15:0] WDATA_I, RDATA_O;
  logic [2:0] ADDR_LOW_I, ADDR_LOW_O;
  logic OPERAND_FETCH_PIN_O, STROBE_O;
  logic [23:0] ACCESS_ADDR_I;
  logic [3:0] INTERRUPT_ARBITRATION_PRIORITY_O;
  logic HALT_O, WDT_RUN_O, BMON_RUN_O, SYSTEM_CLOCK_OUTPUT_PIN_OE_O;
  logic PIPELINE_ADVANCE_PIN_O, PIPELINE_ADVANCE_PIN_OE_O;
  logic OPERAND_FETCH_PIN_OE_O, ADDR_LOW_OE_O, STROBE_OE_O;
  logic SHOW_CYCLE_O, EXT_ARB_ENABLE_O, GRANT_HALTS_O, EXT_SELECT_BLOCK_O;
  logic REGBLOCK_HIT_O, GLOBAL_ACCESS_OK_O, SINGLE_CHIP_O;
  integer seed = 32'h3e57_cca7, mismatches = 0, samples_checked = 0;
  integer cycles = 0, i;
  logic [15:0] a, b, v;

  sysmod_config dut (.*);

  always #5 CLOCK_I = ~CLOCK_I;

  task conclude;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge CLOCK_I) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  // reset with the mode strap held, then wait out the strap capture
  task rst(input logic s);
    @(posedge CLOCK_I);
    ARST_N_I <= 1'b0;
    BUS_ERROR_INPUT_I <= s;
    repeat (4) @(posedge CLOCK_I);
    ARST_N_I <= 1'b1;
    repeat (5) @(posedge CLOCK_I);
    #1;
  endtask

  // one bus cycle; a read compares the data of the following cycle
  task acc(input logic w, input logic [7:0] ad, input logic [15:0] d,
           input logic [15:0] e);
    @(posedge CLOCK_I);
    ADDR_I <= ad;
    WDATA_I <= d;
    WR_I <= w;
    RD_I <= !w;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    #1;
    if (!w) `CHK("rdata", e, RDATA_O)
  endtask

  // random pin stimulus, outputs compared one clock later
  task pins(input logic [15:0] v);
    logic [63:0] r;
    logic [11:0] hi;
    logic hit;
    logic [2:0] sh;
    r = {$random(seed), $random(seed)};
    hi = r[33] ? r[63:52] : (r[32] ? 12'hfff : 12'h7ff);
    @(posedge CLOCK_I);
    {BACKGROUND_DEBUG_STATE_I, BREAKPOINT_I, PIPE_ADVANCE_I,
     OPERAND_FETCH_I, ADDR_LOW_DRIVE_I, STROBE_DRIVE_I, STROBE_I,
     INTERNAL_XFER_I, ACCESS_SUPERVISOR_I} <= r[8:0];
    ADDR_LOW_I <= r[11:9];
    SLOW_REQ_I <= r[19:12];
    ACCESS_ADDR_I <= {hi, r[31:20]};
    @(posedge CLOCK_I);
    #1;
    hit = hi == (v[6] ? 12'hfff : 12'h7ff);
    sh = {v[9:8] != 2'b00, v[9:8] != 2'b01, v[9:8] == 2'b11};
    `CHK("clk_oe", !v[15], SYSTEM_CLOCK_OUTPUT_PIN_OE_O)
    `CHK("wdt", !(r[8] & v[14]), WDT_RUN_O)
    `CHK("bmon", !(r[8] & v[13]), BMON_RUN_O)
    `CHK("pipe_oe", !v[12] | r[7] | r[8], PIPELINE_ADVANCE_PIN_OE_O)
    `CHK("fetch_oe", !v[12] | r[7] | r[8], OPERAND_FETCH_PIN_OE_O)
    `CHK("pipe", r[6], PIPELINE_ADVANCE_PIN_O)
    `CHK("fetch", r[5], OPERAND_FETCH_PIN_O)
    `CHK("addr_low", r[11:9], ADDR_LOW_O)
    `CHK("strobe", r[2], STROBE_O)
    `CHK("slow", r[19:12] & {8{v[10]}}, PIN_SLOW_O)
    `CHK("sel", sh[2] & r[1], EXT_SELECT_BLOCK_O)
    `CHK("show", sh, {SHOW_CYCLE_O, EXT_ARB_ENABLE_O, GRANT_HALTS_O})
    `CHK("ok", hit & (r[0] | !v[7]), GLOBAL_ACCESS_OK_O)
    `CHK("hit", hit, REGBLOCK_HIT_O)
    `CHK("addr_oe", r[4] & !v[5], ADDR_LOW_OE_O)
    `CHK("strobe_oe", r[3] & !v[4], STROBE_OE_O)
    `CHK("interrupt_arbitration_priority", v[3:0], INTERRUPT_ARBITRATION_PRIORITY_O)
    `CHK("halt", r[8], HALT_O)
  endtask

  initial begin
    {ARST_N_I, WR_I, RD_I, BUS_ERROR_INPUT_I, BACKGROUND_DEBUG_STATE_I,
     BREAKPOINT_I, PIPE_ADVANCE_I, OPERAND_FETCH_I, ADDR_LOW_DRIVE_I,
     STROBE_I, STROBE_DRIVE_I, INTERNAL_XFER_I, ACCESS_SUPERVISOR_I} = '0;
    SLOW_REQ_I = '0;
    ADDR_I = '0;
    WDATA_I = '0;
    ADDR_LOW_I = '0;
    ACCESS_ADDR_I = '0;
    for (i = 0; i < 8; i++) begin
      rst(i[0]);
      `CHK("mode", !i[0], SINGLE_CHIP_O)
      `CHK("interrupt_arbitration_priority_rst", 4'hf, INTERRUPT_ARBITRATION_PRIORITY_O)
      acc(1'b0, 8'h00, 16'h0000, i[0] ? 16'h00cf : 16'h10ff);
      a = 16'($random(seed));
      b = 16'($random(seed));
      b[9:8] = i[2:1];
      acc(1'b1, 8'h00, a, 16'h0000);
      acc(1'b1, 8'h00, b, 16'h0000);
      acc(1'b1, 8'h01, 16'($random(seed)), 16'h0000);
      v = (b & 16'hf78f) | (a & 16'h0070);
      acc(1'b0, 8'h00, 16'h0000, v);
      acc(1'b0, 8'h02, 16'h0000, 16'h0000);
      repeat (4) pins(v);
    end
    conclude();
  end
endmodule
